//--- logic/pls_port_lamps.sv
// module: per-port two colour lamp control with boot cable diagnostic
`default_nettype none
// Function
// [R1] A port with a good link has its lamp lit steadily.
// [R2] A linked port with traffic has its lamp blink instead of staying lit.
// [R3] In normal mode a linked port at 10 or 100 Mb/s shows amber.
// [R4] In normal mode a linked port at 1000 Mb/s shows green.
// [R5] The cable diagnostic runs once after power-up and never again.
// [R6] A cable is faulty on an open or a short and good otherwise.
// [R7] During the scan each of the eight lamps blinks green in turn.
// [R8] Results show amber for a faulty cable and green for a good one.
// [R9] Results are shown only after all ports have been scanned.
// [R10] After the result phase a reset pulse is given, then normal mode.
// [R11] Blinks use a slow divided period and ports are scanned in ascending order.
module pls_port_lamps
    import pls_pkg::*;
#(
    parameter int N = NUM_PORTS,
    parameter int HALF_CYC = BLINK_HALF_CYC,
    parameter int SLOT_TICKS = SCAN_SLOT_TICKS,
    parameter int SHOW_TICKS = RESULT_TICKS
)(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // phy link status
    input wire logic [N-1:0] link_up_in,
    input wire logic [N-1:0] activity_in,
    input wire logic [2*N-1:0] speed_in,
    // phy cable test results
    input wire logic cable_done_in,
    input wire logic [N-1:0] cable_open_in,
    input wire logic [N-1:0] cable_short_in,
    // lamp drivers
    output logic [N-1:0] lamp_green_out,
    output logic [N-1:0] lamp_amber_out,
    // switch control
    output logic switch_reset_out,
    output logic normal_mode_out
);
    pls_tick_if tk ();

    pls_blink_div #(
        .HALF_CYC(HALF_CYC)
    ) u_div (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .tk(tk)
    );

    pls_state_type state_q;
    pls_state_type state_d;
    logic [PORT_W-1:0] port_q;
    logic [PORT_W-1:0] port_d;
    logic [7:0] ticks_q;
    logic [7:0] ticks_d;
    logic [N-1:0] fault_q;
    logic [N-1:0] fault_d;
    logic [N-1:0] green_q;
    logic [N-1:0] green_d;
    logic [N-1:0] amber_q;
    logic [N-1:0] amber_d;
    logic rst_pulse_q;
    logic rst_pulse_d;
    logic normal_q;
    logic normal_d;

    // sequencer; only power-on reset returns to the wait state, so one run only
    always_comb
    begin
        state_d = state_q;
        port_d = port_q;
        ticks_d = ticks_q;
        fault_d = fault_q;
        rst_pulse_d = 1'b0;
        unique case (state_q)
            PLS_WAIT_TEST:
            begin
                if (cable_done_in) // [R5]
                begin
                    fault_d = cable_open_in | cable_short_in; // [R6]
                    state_d = PLS_SCAN;
                    port_d = '0;
                    ticks_d = '0;
                end
            end
            PLS_SCAN:
            begin
                if (tk.tick)
                begin
                    ticks_d = ticks_q + 8'h1;
                    if (ticks_q == 8'(SLOT_TICKS - 1))
                    begin
                        ticks_d = '0;
                        if (port_q == PORT_W'(N - 1))
                        begin
                            state_d = PLS_SHOW; // [R9]
                        end
                        else
                        begin
                            port_d = port_q + PORT_W'(1); // [R11]
                        end
                    end
                end
            end
            PLS_SHOW:
            begin
                if (tk.tick)
                begin
                    ticks_d = ticks_q + 8'h1;
                    if (ticks_q == 8'(SHOW_TICKS - 1))
                    begin
                        ticks_d = '0;
                        state_d = PLS_RESTART; // [R10]
                    end
                end
            end
            PLS_RESTART:
            begin
                rst_pulse_d = 1'b1; // [R10]
                ticks_d = ticks_q + 8'h1;
                if (ticks_q == 8'(RESTART_CYC - 1))
                begin
                    rst_pulse_d = 1'b0;
                    ticks_d = '0;
                    state_d = PLS_NORMAL;
                end
            end
            PLS_NORMAL:
            begin
                state_d = PLS_NORMAL; // [R5]
            end
            default:
            begin
                state_d = PLS_WAIT_TEST;
            end
        endcase
        normal_d = (state_d == PLS_NORMAL);
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_q <= PLS_WAIT_TEST;
            port_q <= '0;
            ticks_q <= 8'h0;
            fault_q <= '0;
            rst_pulse_q <= 1'b0;
            normal_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            port_q <= port_d;
            ticks_q <= ticks_d;
            fault_q <= fault_d;
            rst_pulse_q <= rst_pulse_d;
            normal_q <= normal_d;
        end
    end

    // lamp colour per port
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++)
        begin : g_lamp
            logic lit;
            logic gig;
            always_comb
            begin
                gig = (speed_in[2*gi +: 2] == SPEED_1000);
                // traffic blanks the lamp on one blink phase
                lit = link_up_in[gi] & ~(activity_in[gi] & tk.phase); // [R1] [R2]
                green_d[gi] = 1'b0;
                amber_d[gi] = 1'b0;
                unique case (state_q)
                    PLS_SCAN:
                    begin
                        green_d[gi] = (port_q == PORT_W'(gi)) & tk.phase; // [R7]
                    end
                    PLS_SHOW:
                    begin
                        amber_d[gi] = fault_q[gi]; // [R8]
                        green_d[gi] = ~fault_q[gi]; // [R8]
                    end
                    PLS_NORMAL:
                    begin
                        green_d[gi] = lit & gig; // [R4]
                        amber_d[gi] = lit & ~gig; // [R3]
                    end
                    default:
                    begin
                        green_d[gi] = 1'b0;
                        amber_d[gi] = 1'b0;
                    end
                endcase
            end
        end
    endgenerate

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            green_q <= '0;
            amber_q <= '0;
        end
        else
        begin
            green_q <= green_d;
            amber_q <= amber_d;
        end
    end

    assign lamp_green_out = green_q;
    assign lamp_amber_out = amber_q;
    assign switch_reset_out = rst_pulse_q;
    assign normal_mode_out = normal_q;
endmodule : pls_port_lamps
`default_nettype wire

//--- shared/pls_pkg.sv
// package: constants and types for the port lamp and boot cable check block
`default_nettype none
package pls_pkg;
    localparam int NUM_PORTS = 8;
    localparam int PORT_W = 3;
    localparam int CLK_HZ = 100_000_000;
    // blink half period in milliseconds
    localparam int BLINK_HALF_MS = 250;
    localparam int BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;
    // time each port is shown during the scan, in blink half periods
    localparam int SCAN_SLOT_TICKS = 4;
    // time the results stay shown, in blink half periods
    localparam int RESULT_TICKS = 12;
    // cycles spent in the restart state; the reset pulse into normal mode lasts one cycle less
    localparam int RESTART_CYC = 16;
    localparam logic [1:0] SPEED_10 = 2'h0;
    localparam logic [1:0] SPEED_100 = 2'h1;
    localparam logic [1:0] SPEED_1000 = 2'h2;
    typedef enum logic [2:0] {
        PLS_WAIT_TEST = 3'h0,
        PLS_SCAN = 3'h1,
        PLS_SHOW = 3'h3,
        PLS_RESTART = 3'h2,
        PLS_NORMAL = 3'h6
    } pls_state_type;
endpackage : pls_pkg
`default_nettype wire

//--- shared/pls_tick_if.sv
// interface: slow blink tick between divider and main block
`default_nettype none
interface pls_tick_if;
    logic tick;
    logic phase;
    modport src (output tick, output phase);
    modport dst (input tick, input phase);
endinterface : pls_tick_if
`default_nettype wire

//--- logic/pls_blink_div.sv
// module: clock divider producing the slow blink tick and phase
`default_nettype none
module pls_blink_div
    import pls_pkg::*;
#(
    parameter int HALF_CYC = BLINK_HALF_CYC
)(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // tick out
    pls_tick_if.src tk
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic tick_q;
    logic tick_d;
    logic phase_q;
    logic phase_d;

    always_comb
    begin
        tick_d = 1'b0;
        phase_d = phase_q;
        cnt_d = cnt_q + 32'h1;
        if (cnt_q >= 32'(HALF_CYC - 1))
        begin
            cnt_d = 32'h0;
            tick_d = 1'b1;
            phase_d = ~phase_q; // [R11]
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cnt_q <= 32'h0;
            tick_q <= 1'b0;
            phase_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
            phase_q <= phase_d;
        end
    end

    assign tk.tick = tick_q;
    assign tk.phase = phase_q;
endmodule : pls_blink_div
`default_nettype wire

//--- tb/pls_lamp_chk.sv
// checker: lamp colour, blink and restart timing at the block ports
`default_nettype none
module pls_lamp_chk
    import pls_pkg::*;
#(
    parameter int N = NUM_PORTS
)(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // phy status
    input wire logic [N-1:0] link_up_in,
    input wire logic [N-1:0] activity_in,
    input wire logic [2*N-1:0] speed_in,
    // outputs watched
    input wire logic [N-1:0] lamp_green_out,
    input wire logic [N-1:0] lamp_amber_out,
    input wire logic switch_reset_out,
    input wire logic normal_mode_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // bench runs the blink at four cycles a half period
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);
    wire logic up0 = normal_mode_out && link_up_in[0];
    wire logic gig0 = speed_in[1:0] == SPEED_1000;
    wire logic busy0 = up0 && gig0 && activity_in[0];
    sequence restart_pulse;
        switch_reset_out[*8] ##1 switch_reset_out[*7] ##1 !switch_reset_out;
    endsequence
    // busy throughout, lamp lit for a whole half period; traffic must then blank it
    sequence busy_lit_half;
        busy0 ##1 (busy0 && lamp_green_out[0])[*4];
    endsequence
    chk_green_gig: assert property (up0 && gig0 && !activity_in[0] |=>
        lamp_green_out[0] && !lamp_amber_out[0]) else $error("gig lamp not green");
    chk_amber_slow: assert property (up0 && !gig0 && !activity_in[0] |=>
        lamp_amber_out[0] && !lamp_green_out[0]) else $error("slow lamp not amber");
    chk_dark_nolink: assert property (normal_mode_out && !link_up_in[0] |=>
        !lamp_green_out[0] && !lamp_amber_out[0]) else $error("unlinked lamp lit");
    chk_act_blinks: assert property (busy_lit_half |=> !lamp_green_out[0])
        else $error("busy lamp not blinking");
    chk_restart_dark: assert property (switch_reset_out |->
        lamp_green_out == '0 && lamp_amber_out == '0) else $error("lamp lit in restart");
    chk_restart_len: assert property ($rose(switch_reset_out) |-> restart_pulse)
        else $error("restart pulse length wrong");
    chk_mode_after: assert property ($fell(switch_reset_out) |-> ##[0:1] normal_mode_out)
        else $error("no normal mode after restart");
    chk_mode_sticks: assert property (normal_mode_out |=>
        normal_mode_out && !switch_reset_out) else $error("normal mode left");
endmodule : pls_lamp_chk
bind pls_port_lamps pls_lamp_chk #(.N(N)) u_chk (.ref_clk_in(ref_clk_in),
    .rst_in(rst_in), .link_up_in(link_up_in), .activity_in(activity_in),
    .speed_in(speed_in), .lamp_green_out(lamp_green_out),
    .lamp_amber_out(lamp_amber_out), .switch_reset_out(switch_reset_out),
    .normal_mode_out(normal_mode_out));
`default_nettype wire

//--- tb/pls_phy_model.sv
// model: phy cable tester giving one result pulse after reset and one more on each rerun_in request
`default_nettype none
module pls_phy_model
    import pls_pkg::*;
#(
    parameter logic [7:0] OPEN_MASK = 8'h05,
    parameter logic [7:0] SHORT_MASK = 8'h20,
    parameter int TEST_CYC = 20
)(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // bench control
    input wire logic rerun_in,
    // cable test results
    output logic cable_done_out,
    output logic [7:0] cable_open_out,
    output logic [7:0] cable_short_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    always @(negedge ref_clk_in)
    begin
        cnt <= rst_in ? 0 : cnt + 1;
    end
    // results outside the valid pulse are junk, never the held value
    assign cable_done_out = cnt == TEST_CYC || rerun_in;
    assign cable_open_out = cable_done_out ? OPEN_MASK : ~OPEN_MASK;
    assign cable_short_out = cable_done_out ? SHORT_MASK : ~SHORT_MASK;
endmodule : pls_phy_model
`default_nettype wire

//--- tb/tb_top.sv
// testbench: boot scan, results, restart and normal lamp scenarios
`default_nettype none
module tb_top import pls_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, rerun = 0, done, swr, nrm;
    logic [7:0] link = 0, act = 0, opn, sht, grn, amb;
    logic [15:0] spd = 0;
    int errors = 0, num_checks = 0;
    pls_port_lamps #(.HALF_CYC(4)) dut (.ref_clk_in(clk), .rst_in(rst),
        .link_up_in(link), .activity_in(act), .speed_in(spd),
        .cable_done_in(done), .cable_open_in(opn), .cable_short_in(sht),
        .lamp_green_out(grn), .lamp_amber_out(amb),
        .switch_reset_out(swr), .normal_mode_out(nrm));
    pls_phy_model phy (.ref_clk_in(clk), .rst_in(rst), .rerun_in(rerun),
        .cable_done_out(done), .cable_open_out(opn), .cable_short_out(sht));
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task automatic t_boot;
        int seen[$];
        int k;
        k = 0;
        while (amb === 8'h00 && k < 400)
        begin
            @(negedge clk);
            k++;
            if (amb === 8'h00 && grn != 0 && (seen.size() == 0 || seen[$] != $clog2(grn)))
                seen.push_back($clog2(grn));
        end
        check("scan ports", 16'(seen.size()), 16'h0008);
        foreach (seen[i]) check("scan order", 16'(seen[i]), 16'(i));
        check("result amber", amb, 8'h25);
        check("result green", grn, 8'hDA);
        k = 0;
        while (swr !== 1'b1 && k < 200)
        begin
            @(negedge clk);
            k++;
        end
        k = 0;
        while (swr === 1'b1 && k < 40)
        begin
            @(negedge clk);
            k++;
        end
        check("restart len", 16'(k), 16'h000F);
        check("normal mode", nrm, 1'b1);
    endtask : t_boot
    task automatic t_normal;
        logic lo, hi;
        spd = 16'h1AD2;
        link = 8'hEF;
        repeat (2) @(negedge clk);
        check("link green", grn, 8'h21);
        check("link amber", amb, 8'hCE);
        act = 8'h01;
        lo = 0;
        hi = 0;
        repeat (12)
        begin
            @(negedge clk);
            lo |= grn[0] === 1'b0;
            hi |= grn[0] === 1'b1;
        end
        check("blink", {lo, hi}, 2'h3);
        act = 8'h00;
    endtask : t_normal
    task automatic t_rerun;
        spd = 16'h0000;
        link = 8'hFF;
        rerun = 1;
        @(negedge clk);
        rerun = 0;
        repeat (20) @(negedge clk);
        check("no rerun amber", amb, 8'hFF);
        check("no rerun green", grn, 8'h00);
        check("no rerun reset", swr, 1'b0);
        link = 8'h00;
        repeat (2) @(negedge clk);
        check("dark lamps", {grn, amb}, 16'h0000);
    endtask : t_rerun
    initial forever #5 clk = ~clk;
    initial
    begin
        #20000;
        errors++;
        give_verdict();
    end
    initial
    begin
        repeat (2) @(negedge clk);
        rst = 0;
        t_boot();
        t_normal();
        t_rerun();
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
